// >>> pkg/tmb_map.svh
// Register map, field positions, reset values and codes of the 16-bit timer block.
// Included by the timer design and the bench; holds definitions only.
`ifndef TMB_MAP_SVH
`define TMB_MAP_SVH

`define TMB_OFS_CTRL       8'h00
`define TMB_OFS_CNT_LO     8'h04
`define TMB_OFS_CNT_HI     8'h08
`define TMB_OFS_FLAG       8'h0C
`define TMB_OFS_IEN        8'h10
`define TMB_OFS_AUX        8'h14

`define TMB_CTRL_RST       8'h00
`define TMB_BYTE_ZERO      8'h00
`define TMB_CNT_ZERO       16'h0000
`define TMB_CNT_MAX        16'hFFFF
`define TMB_CNT_ONE        16'h0001
`define TMB_WORD_ZERO      32'h00000000

`define TMB_FLAG_BIT       1
`define TMB_IEN_BIT        1
`define TMB_AUX_OSC_BIT    0
`define TMB_AUX_ADC_BIT    1

`define TMB_SPECIAL_EVENT  4'hB

`define TMB_PSC_ZERO       3'h0
`define TMB_PSC_ONE        3'h1
`define TMB_PSC_LAST_DIV1  3'h0
`define TMB_PSC_LAST_DIV2  3'h1
`define TMB_PSC_LAST_DIV4  3'h3
`define TMB_PSC_LAST_DIV8  3'h7
`define TMB_PSC_CODE_DIV1  2'h0
`define TMB_PSC_CODE_DIV2  2'h1
`define TMB_PSC_CODE_DIV4  2'h2

`endif

// >>> pkg/tmb_pkg.sv
// Types shared by the 16-bit timer block.
// Assumes the constants of tmb_map.svh are included where the types are used.
package tmb_pkg;

	typedef struct packed {
		logic       wide_access_mode;
		logic       route_sel_hi;
		logic [1:0] prescale_sel;
		logic       route_sel_lo;
		logic       ext_sync_disable;
		logic       ext_clock_select;
		logic       counter_on;
	} tmb_ctrl_s;

	typedef struct packed {
		logic [3:0] first_cmp_mode;
		logic       first_cmp_event;
		logic [3:0] second_cmp_mode;
		logic       second_cmp_event;
	} tmb_cmp_s;

	typedef enum logic [1:0] {
		TMB_WAIT_FALL = 2'b01,
		TMB_ARMED     = 2'b10
	} tmb_arm_e;

endpackage

// >>> design/tmb_sync.sv
// Two-stage synchroniser for the external count clock.
// Assumes one clock domain; only the second stage may be read outside.
`timescale 1ns/1ps
module tmb_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      sync_out
);

	logic stage1_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1_reg <= 1'b0;
			sync_out   <= 1'b0;
		end else begin
			stage1_reg <= async_in;
			sync_out   <= stage1_reg;
		end
	end

endmodule

// >>> design/tmb_timer.sv
// Sixteen-bit up counter with prescaler, wide access buffer and special event reset.
// Assumes an APB master on pclk, inputs synchronous to pclk, and one compare event
// pulse per unit lasting one cycle.
`timescale 1ns/1ps
`include "tmb_map.svh"

module tmb_timer (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic                  pready,
	output logic [31:0]           prdata,
	output logic                  pslverr,
	input  wire tmb_pkg::tmb_cmp_s cmp_in,
	input  wire logic             ext_count_clock_pin,
	input  wire logic             shared_osc_clk,
	input  wire logic [1:0]       osc_pin_in,
	input  wire logic [1:0]       osc_pin_dir_out,
	output logic [1:0]            osc_pin_rd,
	output logic [1:0]            osc_pin_oe,
	output logic                  irq_req,
	output logic                  first_unit_uses_timer,
	output logic                  second_unit_uses_timer,
	output logic                  adc_start
);

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		addr_is = (a == ofs);
	endfunction

	tmb_pkg::tmb_ctrl_s ctrl_reg;
	tmb_pkg::tmb_arm_e  arm_reg;
	tmb_pkg::tmb_arm_e  arm_next;
	logic [15:0]        count_reg;
	logic [15:0]        count_next;
	logic [7:0]         hbuf_reg;
	logic [7:0]         stage_reg;
	logic [2:0]         psc_reg;
	logic [2:0]         psc_next;
	logic               ovf_flag_reg;
	logic               ovf_ien_reg;
	logic               osc_en_reg;
	logic               adc_en_reg;
	logic               src_prev_reg;

	// Bus phases: a transfer completes in the first cycle of the access phase.
	wire setup    = psel & ~penable;
	wire complete = psel & penable & pready;
	wire wr_done  = complete & pwrite;
	wire rd_done  = complete & ~pwrite;

	wire hit_ctrl = addr_is(paddr, `TMB_OFS_CTRL);
	wire hit_lo   = addr_is(paddr, `TMB_OFS_CNT_LO);
	wire hit_hi   = addr_is(paddr, `TMB_OFS_CNT_HI);
	wire hit_flag = addr_is(paddr, `TMB_OFS_FLAG);
	wire hit_ien  = addr_is(paddr, `TMB_OFS_IEN);
	wire hit_aux  = addr_is(paddr, `TMB_OFS_AUX);
	wire hit_any  = hit_ctrl | hit_lo | hit_hi | hit_flag | hit_ien | hit_aux;

	wire wr_lo   = wr_done & hit_lo;
	wire wr_hi   = wr_done & hit_hi;
	wire cnt_wr  = wr_lo | (wr_hi & ~ctrl_reg.wide_access_mode);
	wire wide    = ctrl_reg.wide_access_mode;

	wire [7:0] hi_view = wide ? hbuf_reg : count_reg[15:8];

	wire [7:0] rd_byte = hit_ctrl ? ctrl_reg :
		hit_lo ? count_reg[7:0] :
		hit_hi ? hi_view :
		hit_flag ? (8'(ovf_flag_reg) << `TMB_FLAG_BIT) :
		hit_ien ? (8'(ovf_ien_reg) << `TMB_IEN_BIT) :
		hit_aux ? ((8'(osc_en_reg) << `TMB_AUX_OSC_BIT) | (8'(adc_en_reg) << `TMB_AUX_ADC_BIT)) :
		`TMB_BYTE_ZERO;

	wire route_first  = ctrl_reg.route_sel_hi;
	wire route_second = ctrl_reg.route_sel_hi | ctrl_reg.route_sel_lo;

	wire trig_first  = route_first & cmp_in.first_cmp_event
		& (cmp_in.first_cmp_mode == `TMB_SPECIAL_EVENT);
	wire trig_second = route_second & cmp_in.second_cmp_event
		& (cmp_in.second_cmp_mode == `TMB_SPECIAL_EVENT);
	wire trig        = trig_first | trig_second;

	wire raw_src = osc_en_reg ? shared_osc_clk : ext_count_clock_pin;
	logic synced_src;

	tmb_sync u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (raw_src),
		.sync_out (synced_src)
	);

	wire src      = ctrl_reg.ext_sync_disable ? raw_src : synced_src;
	wire src_rise = src & ~src_prev_reg;
	wire src_fall = ~src & src_prev_reg;
	wire ext_run  = ctrl_reg.counter_on & ctrl_reg.ext_clock_select;

	always_comb begin
		arm_next = arm_reg;
		case (arm_reg)
			tmb_pkg::TMB_WAIT_FALL: begin
				if (ext_run && src_fall) begin
					arm_next = tmb_pkg::TMB_ARMED;
				end
			end
			tmb_pkg::TMB_ARMED: begin
				if (!ext_run) begin
					arm_next = tmb_pkg::TMB_WAIT_FALL;
				end
			end
			default: begin
				arm_next = tmb_pkg::TMB_WAIT_FALL;
			end
		endcase
	end

	// count event per cycle or external rise
	wire edge_evt = ctrl_reg.ext_clock_select
		? ((arm_reg == tmb_pkg::TMB_ARMED) & src_rise) : 1'b1;
	wire run_evt  = ctrl_reg.counter_on & edge_evt;

	wire [2:0] psc_last =
		(ctrl_reg.prescale_sel == `TMB_PSC_CODE_DIV1) ? `TMB_PSC_LAST_DIV1 :
		(ctrl_reg.prescale_sel == `TMB_PSC_CODE_DIV2) ? `TMB_PSC_LAST_DIV2 :
		(ctrl_reg.prescale_sel == `TMB_PSC_CODE_DIV4) ? `TMB_PSC_LAST_DIV4 :
		`TMB_PSC_LAST_DIV8;
	wire psc_hit  = run_evt & (psc_reg >= psc_last);
	wire inc      = psc_hit & ~cnt_wr & ~trig;
	wire wrap     = inc & (count_reg == `TMB_CNT_MAX);

	// prescaler cleared by low write or on reaching its last count
	assign psc_next = wr_lo ? `TMB_PSC_ZERO :
		psc_hit ? `TMB_PSC_ZERO :
		run_evt ? psc_reg + `TMB_PSC_ONE : psc_reg;

	// write beats trigger, trigger beats increment
	assign count_next = wr_lo ? {(wide ? hbuf_reg : count_reg[15:8]), pwdata[7:0]} :
		(wr_hi && !wide) ? {pwdata[7:0], count_reg[7:0]} :
		trig ? `TMB_CNT_ZERO :
		inc ? count_reg + `TMB_CNT_ONE : count_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg    <= `TMB_CNT_ZERO;
			psc_reg      <= `TMB_PSC_ZERO;
			arm_reg      <= tmb_pkg::TMB_WAIT_FALL;
			src_prev_reg <= 1'b0;
		end else begin
			count_reg    <= count_next;
			psc_reg      <= psc_next;
			arm_reg      <= arm_next;
			src_prev_reg <= src;
		end
	end

	// buffer loads: snapshot at setup, commit at completion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_reg <= `TMB_BYTE_ZERO;
			hbuf_reg  <= `TMB_BYTE_ZERO;
		end else begin
			if (setup && hit_lo) begin
				stage_reg <= count_reg[15:8];
			end
			if (wide && wr_hi) begin
				hbuf_reg <= pwdata[7:0];
			end else if (wide && rd_done && hit_lo) begin
				hbuf_reg <= stage_reg;
			end
		end
	end

	// Control and side registers; the flag set wins over a software clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg     <= `TMB_CTRL_RST;
			ovf_flag_reg <= 1'b0;
			ovf_ien_reg  <= 1'b0;
			osc_en_reg   <= 1'b0;
			adc_en_reg   <= 1'b0;
		end else begin
			if (wr_done && hit_ctrl) begin
				ctrl_reg <= pwdata[7:0];
			end
			if (wrap) begin
				ovf_flag_reg <= 1'b1;
			end else if (wr_done && hit_flag) begin
				ovf_flag_reg <= pwdata[`TMB_FLAG_BIT];
			end
			if (wr_done && hit_ien) begin
				ovf_ien_reg <= pwdata[`TMB_IEN_BIT];
			end
			if (wr_done && hit_aux) begin
				osc_en_reg <= pwdata[`TMB_AUX_OSC_BIT];
				adc_en_reg <= pwdata[`TMB_AUX_ADC_BIT];
			end
		end
	end

	// Read data is prepared at setup, so each access phase takes exactly one cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `TMB_WORD_ZERO;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit_any;
			if (setup && !pwrite) begin
				prdata <= {24'h000000, rd_byte};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_req                <= 1'b0;
			adc_start              <= 1'b0;
			first_unit_uses_timer  <= 1'b0;
			second_unit_uses_timer <= 1'b0;
		end else begin
			irq_req                <= ovf_flag_reg & ovf_ien_reg;
			adc_start              <= trig & adc_en_reg;
			first_unit_uses_timer  <= route_first;
			second_unit_uses_timer <= route_second;
		end
	end

	// oscillator pins disabled while oscillator runs
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_oscpin
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					osc_pin_rd[gi] <= 1'b0;
					osc_pin_oe[gi] <= 1'b0;
				end else begin
					osc_pin_rd[gi] <= ~osc_en_reg & osc_pin_in[gi];
					osc_pin_oe[gi] <= ~osc_en_reg & osc_pin_dir_out[gi];
				end
			end
		end
	endgenerate

	wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		wrap |=> ovf_flag_reg && (count_reg == `TMB_CNT_ZERO))
		else $error("Wrap did not zero the counter and set the flag.");

	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq_req |-> $past(ovf_flag_reg) && $past(ovf_ien_reg))
		else $error("Interrupt raised without flag and enable.");

	trig_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		trig && !cnt_wr |=> count_reg == `TMB_CNT_ZERO)
		else $error("Special event did not clear the counter.");

	write_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		trig && wr_lo |=> count_reg[7:0] == $past(pwdata[7:0]))
		else $error("Trigger overrode a counter write.");

	adc_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
		trig && adc_en_reg |=> adc_start)
		else $error("Special event did not start a conversion.");

	trig_noflag_a: assert property (@(posedge pclk) disable iff (!presetn)
		trig && !ovf_flag_reg && !(wr_done && hit_flag) |=> !ovf_flag_reg)
		else $error("Special event set the overflow flag.");

	psc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_lo |=> psc_reg == `TMB_PSC_ZERO)
		else $error("Low write did not clear the prescaler.");

	stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ctrl_reg.counter_on && !cnt_wr && !trig |=> $stable(count_reg))
		else $error("Counter moved while stopped.");

	wide_hi_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && hit_hi && wide |=> prdata[7:0] == $past(hbuf_reg))
		else $error("Wide high read bypassed the buffer.");

	osc_pins_a: assert property (@(posedge pclk) disable iff (!presetn)
		osc_en_reg |=> osc_pin_rd == 2'h0 && osc_pin_oe == 2'h0)
		else $error("Oscillator pins active while oscillator enabled.");

	div_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_reg.counter_on && !ctrl_reg.ext_clock_select
		&& ctrl_reg.prescale_sel == `TMB_PSC_CODE_DIV1 && !cnt_wr && !trig
		&& count_reg != `TMB_CNT_MAX |=> count_reg == $past(count_reg) + `TMB_CNT_ONE)
		else $error("Undivided internal count did not advance by one.");

endmodule

// >>> tb/tmb_far_model.sv
// Far side of the timer: two compare units and the two external count clock sources.
// Assumes its tasks are called from the pclk domain; the sources stand still between calls.
`timescale 1ns/1ps
module tmb_far_model (
	input  wire logic          pclk,
	output tmb_pkg::tmb_cmp_s  cmp,
	output logic               ext_pin,
	output logic               osc_clk
);
	initial begin
		cmp = '0;
		ext_pin = 1'b0;
		osc_clk = 1'b0;
	end
	// slow source edges
	// Edges come several cycles apart, so a synchronised counter can follow them.
	task automatic pulse(input logic use_osc, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge pclk);
			if (use_osc)
				osc_clk <= ~osc_clk;
			else
				ext_pin <= ~ext_pin;
		end
	endtask
	task automatic fire(input logic second, input logic [3:0] mode);
		@(posedge pclk);
		cmp.first_cmp_mode <= mode;
		cmp.second_cmp_mode <= mode;
		cmp.first_cmp_event <= !second;
		cmp.second_cmp_event <= second;
		@(posedge pclk);
		cmp.first_cmp_event <= 1'b0;
		cmp.second_cmp_event <= 1'b0;
	endtask
endmodule

// >>> tb/sixteen_bit_timer_counter_bench.sv
// Self-checking bench of the 16-bit timer: APB master, far-side model, tables of cases.
// Assumes the timer answers each APB access without waits and holds no long counts.
`timescale 1ns/1ps
`include "tmb_map.svh"
`define TMB_CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module sixteen_bit_timer_counter_bench;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata, q;
	tmb_pkg::tmb_cmp_s cmp;
	logic              ext_pin, osc_clk, irq_req, first_use, second_use, adc_start;
	logic [1:0]        pin_rd, pin_oe;
	int                miscompares, tests_run, e;
	logic [9:0]        rows [4] = '{10'h000, 10'h061, 10'h183, 10'h1E3};
	logic [16:0]       scr [23] = '{17'h108FF, 17'h104FE, 17'h10001, 17'h10000, 17'h00C02,
		17'h00800, 17'h10080, 17'h10812, 17'h10000, 17'h00800, 17'h10080, 17'h10434,
		17'h10000, 17'h00812, 17'h00434, 17'h10080, 17'h10856, 17'h10000, 17'h10877,
		17'h10080, 17'h00856, 17'h00434, 17'h00877};
	logic [20:0]       trg [5] = '{21'h01B50, 21'h10B50, 21'h80A50, 21'h11B00, 21'h80B00};
	logic [10:0]       ext [3] = '{11'h406, 11'h40E, 11'h607};

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		miscompares = 0;
		tests_run = 0;
	end
	always #25 pclk = ~pclk;

	tmb_timer i_tmb_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .cmp_in(cmp), .ext_count_clock_pin(ext_pin),
		.shared_osc_clk(osc_clk), .osc_pin_in(2'b11), .osc_pin_dir_out(2'b11),
		.osc_pin_rd(pin_rd), .osc_pin_oe(pin_oe), .irq_req(irq_req),
		.first_unit_uses_timer(first_use), .second_unit_uses_timer(second_use),
		.adc_start(adc_start));
	tmb_far_model i_tmb_far_model (.pclk(pclk), .cmp(cmp), .ext_pin(ext_pin),
		.osc_clk(osc_clk));

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task give_verdict;
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		#(50 * 8000);
		miscompares++;
		give_verdict;
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 6; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0);
			`TMB_CHK(q, `TMB_WORD_ZERO)
		end
		apb(1'b1, 8'h18, 32'hFF);
		`TMB_CHK(err, 1'b1)
		foreach (rows[i]) begin
			apb(1'b1, `TMB_OFS_CTRL, {24'h0, rows[i][9:2]});
			apb(1'b0, `TMB_OFS_CTRL, 32'h0);
			`TMB_CHK(q[7:0], rows[i][9:2])
			`TMB_CHK({first_use, second_use}, rows[i][1:0])
			apb(1'b1, `TMB_OFS_CNT_HI, 32'h0);
			apb(1'b1, `TMB_OFS_CNT_LO, 32'h0);
			apb(1'b1, `TMB_OFS_CTRL, {24'h0, rows[i][9:3], 1'b1});
			repeat (64) @(posedge pclk);
			apb(1'b1, `TMB_OFS_CTRL, {24'h0, rows[i][9:2]});
			apb(1'b0, `TMB_OFS_CNT_LO, 32'h0);
			e = 67 >> rows[i][7:6];
			`TMB_CHK(q[7:0] + 1 >= e && q[7:0] <= e + 1, 1'b1)
		end
		foreach (scr[i]) begin
			apb(scr[i][16], scr[i][15:8], {24'h0, scr[i][7:0]});
			if (!scr[i][16] && scr[i][15:8] != `TMB_OFS_FLAG)
				`TMB_CHK(q[7:0], scr[i][7:0])
			if (scr[i][15:8] == `TMB_OFS_FLAG)
				`TMB_CHK(q[7:0], 8'h02)
		end
		`TMB_CHK(irq_req, 1'b0)
		apb(1'b1, `TMB_OFS_IEN, 32'h2);
		apb(1'b0, `TMB_OFS_IEN, 32'h0);
		`TMB_CHK(irq_req, 1'b1)
		apb(1'b1, `TMB_OFS_FLAG, 32'h0);
		apb(1'b0, `TMB_OFS_FLAG, 32'h0);
		`TMB_CHK(irq_req, 1'b0)
		apb(1'b1, `TMB_OFS_AUX, 32'h2);
		foreach (trg[i]) begin
			apb(1'b1, `TMB_OFS_CTRL, {24'h0, trg[i][20:13]});
			apb(1'b1, `TMB_OFS_CNT_LO, 32'h50);
			i_tmb_far_model.fire(trg[i][12], trg[i][11:8]);
			#1;
			`TMB_CHK(adc_start, trg[i][7:0] == 8'h00)
			apb(1'b0, `TMB_OFS_CNT_LO, 32'h0);
			`TMB_CHK(q[7:0], trg[i][7:0])
		end
		fork
			apb(1'b1, `TMB_OFS_CNT_LO, 32'h5A);
			begin
				@(posedge pclk);
				i_tmb_far_model.fire(1'b0, `TMB_SPECIAL_EVENT);
			end
		join
		apb(1'b0, `TMB_OFS_CNT_LO, 32'h0);
		`TMB_CHK(q[7:0], 8'h5A)
		apb(1'b0, `TMB_OFS_FLAG, 32'h0);
		`TMB_CHK(q[7:0], 8'h00)
		foreach (ext[i]) begin
			apb(1'b1, `TMB_OFS_AUX, {30'h0, ext[i][10:9]});
			apb(1'b1, `TMB_OFS_CTRL, 32'h0);
			apb(1'b1, `TMB_OFS_CNT_LO, 32'h0);
			apb(1'b1, `TMB_OFS_CTRL, {24'h0, ext[i][8:1]});
			i_tmb_far_model.pulse(ext[i][0], 6);
			repeat (8) @(posedge pclk);
			apb(1'b1, `TMB_OFS_CTRL, 32'h0);
			apb(1'b0, `TMB_OFS_CNT_LO, 32'h0);
			`TMB_CHK(q[7:0], 8'h02)
			`TMB_CHK({pin_rd, pin_oe}, ext[i][9] ? 4'h0 : 4'hF)
		end
		give_verdict;
	end
endmodule
